// ===== rtl/mmt_cfg.svh
// Offsets, reset values and counts of the shared timer 2/3/4 block.
`ifndef MMT_CFG_SVH
`define MMT_CFG_SVH
// Register offsets on the byte-wide port.
`define MMT_OFS_CTRL 8'hC8
`define MMT_OFS_MODE 8'hC9
`define MMT_OFS_RCAPL 8'hCA
`define MMT_OFS_RCAPH 8'hCB
`define MMT_OFS_CNTL 8'hCC
`define MMT_OFS_CNTH 8'hCD
`define MMT_OFS_PTR 8'hCE
`define MMT_OFS_IEN 8'hCF
// Pointer codes and reset value.
`define MMT_PTR_T2 3'h2
`define MMT_PTR_T4 3'h4
`define MMT_PTR_RST 3'h2
// Register reset values.
`define MMT_CTRL_RST 8'h00
`define MMT_MODE_RST 8'h00
`define MMT_WORD_RST 16'h0000
`define MMT_IEN_RST 4'h0
// Top count and slow clock divider.
`define MMT_CNT_MAX 16'hFFFF
`define MMT_PRESC_LAST 4'hB
`endif

// ===== rtl/mmt_pkg.sv
// Types shared by the timer 2/3/4 block.
package mmt_pkg;
   // Control register layout, bit 7 first.
   typedef struct packed {
      logic tf;
      logic exf;
      logic rclk;
      logic transmit_clock_select;
      logic exen;
      logic run;
      logic ct;
      logic cprl;
   } mmt_ctl_t;
   // Mode register layout, bit 7 first.
   typedef struct packed {
      logic fd;
      logic rsv;
      logic [3:0] pwm;
      logic oe;
      logic down_count_enable;
   } mmt_mod_t;
   // Operating modes, one-hot.
   typedef enum logic [3:0] {
      MMT_CAPTURE = 4'h1,
      MMT_RELOAD = 4'h2,
      MMT_BAUD = 4'h4,
      MMT_CLKOUT = 4'h8
   } mmt_mode_t;
endpackage : mmt_pkg

// ===== rtl/mmt_timer.sv
// Shared timer 2/3/4 block with pointer-selected register set.
`include "mmt_cfg.svh"
module mmt_timer (
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic [7:0] BUS_ADDR_IN,
   input wire logic [7:0] BUS_WDATA_IN,
   input wire logic BUS_WR_IN,
   input wire logic BUS_RD_IN,
   output logic [7:0] BUS_RDATA_OUT,
   input wire logic [2:0] EXT_TRIG_IN,
   input wire logic [2:0] TIMER_PIN_IN,
   output logic [2:0] TIMER_PIN_OUT,
   output logic [2:0] TIMER_PIN_OE_OUT,
   output logic [2:0] IRQ_OUT,
   output logic BAUD_TX_TICK_OUT,
   output logic BAUD_RX_TICK_OUT
);
   // Decodes the mode of one timer; only timer 2 may be a baud source.
   function automatic mmt_pkg::mmt_mode_t mode_of(input mmt_pkg::mmt_ctl_t c,
         input mmt_pkg::mmt_mod_t m, input logic is_t2);
      // Clock output wins, then baud, then capture, else reload.
      if (!c.ct && m.oe) begin
         mode_of = mmt_pkg::MMT_CLKOUT;
      end else if (is_t2 && (c.rclk || c.transmit_clock_select)) begin
         mode_of = mmt_pkg::MMT_BAUD;
      end else if (c.cprl) begin
         mode_of = mmt_pkg::MMT_CAPTURE;
      end else begin
         mode_of = mmt_pkg::MMT_RELOAD;
      end
   endfunction

   // Pointer to the visible register set.
   logic [2:0] ptr_r;
   // Per-timer control and mode registers.
   mmt_pkg::mmt_ctl_t ctl_r [3];
   mmt_pkg::mmt_mod_t mod_r [3];
   // Per-timer count and capture/reload words.
   logic [15:0] cnt_r [3];
   logic [15:0] rcap_r [3];
   // Global enable in bit 0, timer enables above it.
   logic [3:0] ien_r;
   // Slow clock divider and its tick.
   logic [3:0] presc_r;
   logic presc_tick;
   // Two-stage synchronisers and the previous settled sample.
   logic [2:0] trig_s1_r, trig_s2_r, trig_s3_r;
   logic [2:0] tpin_s1_r, tpin_s2_r, tpin_s3_r;
   // Half-period divider and pin level for clock output.
   logic [2:0] half_r;
   logic [2:0] clk_r;
   // Per-timer decoded events.
   mmt_pkg::mmt_mode_t mode [3];
   logic [2:0] sel, tick, ext_ev, down_count_enable_md, up, ovf;
   logic [15:0] cnt_nxt [3];
   // Bus decode shared by all timers.
   logic ptr_ok;

   assign ptr_ok = (ptr_r >= `MMT_PTR_T2) && (ptr_r <= `MMT_PTR_T4);

   // The pointer register itself; reserved codes are stored but reach nothing.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ptr_r <= `MMT_PTR_RST;
      end else if (BUS_WR_IN && BUS_ADDR_IN == `MMT_OFS_PTR) begin
         ptr_r <= BUS_WDATA_IN[2:0];
      end
   end

   // Interrupt enables: bit 0 global, bits 1 to 3 for timers 2 to 4.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ien_r <= `MMT_IEN_RST;
      end else if (BUS_WR_IN && BUS_ADDR_IN == `MMT_OFS_IEN) begin
         ien_r <= BUS_WDATA_IN[3:0];
      end
   end

   // Divide-by-12 prescaler shared by all timers.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         presc_r <= 4'h0;
      end else if (presc_r == `MMT_PRESC_LAST) begin
         presc_r <= 4'h0;
      end else begin
         presc_r <= presc_r + 4'h1;
      end
   end
   assign presc_tick = (presc_r == `MMT_PRESC_LAST);

   // pin synchronisers
   // Only the second stage and its delayed copy feed any logic.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         trig_s1_r <= 3'h7;
         trig_s2_r <= 3'h7;
         trig_s3_r <= 3'h7;
         tpin_s1_r <= 3'h7;
         tpin_s2_r <= 3'h7;
         tpin_s3_r <= 3'h7;
      end else begin
         trig_s1_r <= EXT_TRIG_IN;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
         tpin_s1_r <= TIMER_PIN_IN;
         tpin_s2_r <= tpin_s1_r;
         tpin_s3_r <= tpin_s2_r;
      end
   end

   // Per-timer event decode; the loop covers the three timers.
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         sel[i] = ptr_ok && (ptr_r - `MMT_PTR_T2 == 3'(i));
         mode[i] = mode_of(ctl_r[i], mod_r[i], i == 0);
         down_count_enable_md[i] = (mode[i] == mmt_pkg::MMT_RELOAD) && mod_r[i].down_count_enable;
         up[i] = !down_count_enable_md[i] || trig_s2_r[i];
         if (!ctl_r[i].run) begin
            tick[i] = 1'b0;
         end else if (mode[i] == mmt_pkg::MMT_BAUD) begin
            tick[i] = 1'b1;
         end else if (ctl_r[i].ct && mode[i] != mmt_pkg::MMT_CLKOUT) begin
            // Counter mode counts falling edges on the timer pin.
            tick[i] = tpin_s3_r[i] && !tpin_s2_r[i];
         end else begin
            tick[i] = mod_r[i].fd || presc_tick;
         end
         // falling edge, exen ignored when down counting
         ext_ev[i] = trig_s3_r[i] && !trig_s2_r[i] && ctl_r[i].exen && !down_count_enable_md[i];
         ovf[i] = tick[i] && (up[i] ? (cnt_r[i] == `MMT_CNT_MAX) : (cnt_r[i] == rcap_r[i]));
         // Next count before software overrides.
         if (ovf[i] && !up[i]) begin
            cnt_nxt[i] = `MMT_CNT_MAX;
         end else if (ovf[i] && mode[i] != mmt_pkg::MMT_CAPTURE) begin
            cnt_nxt[i] = rcap_r[i];
         end else if (ext_ev[i] && mode[i] == mmt_pkg::MMT_RELOAD) begin
            cnt_nxt[i] = rcap_r[i];
         end else if (tick[i]) begin
            // plain count, capture wraps to zero
            cnt_nxt[i] = up[i] ? cnt_r[i] + 16'h0001 : cnt_r[i] - 16'h0001;
         end else begin
            cnt_nxt[i] = cnt_r[i];
         end
      end
   end

   // Per-timer registers; bus writes reach only the selected timer.
   // hardware set wins
   // A hardware flag set in the same cycle as a software clear wins.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < 3; i++) begin
            ctl_r[i] <= `MMT_CTRL_RST;
            mod_r[i] <= `MMT_MODE_RST;
            cnt_r[i] <= `MMT_WORD_RST;
            rcap_r[i] <= `MMT_WORD_RST;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            // Control register write; baud selects exist on timer 2 only.
            if (BUS_WR_IN && sel[i] && BUS_ADDR_IN == `MMT_OFS_CTRL) begin
               ctl_r[i] <= BUS_WDATA_IN;
               if (i != 0) begin
                  ctl_r[i].rclk <= 1'b0;
                  ctl_r[i].transmit_clock_select <= 1'b0;
               end
            end
            // no tf flag in clock or baud mode
            if (ovf[i] && (mode[i] == mmt_pkg::MMT_CAPTURE ||
                  mode[i] == mmt_pkg::MMT_RELOAD)) begin
               ctl_r[i].tf <= 1'b1;
            end
            if (down_count_enable_md[i] && ovf[i]) begin
               ctl_r[i].exf <= !ctl_r[i].exf;
            end else if (ext_ev[i]) begin
               ctl_r[i].exf <= 1'b1;
            end
            // Mode register write; the reserved bit stays zero.
            if (BUS_WR_IN && sel[i] && BUS_ADDR_IN == `MMT_OFS_MODE) begin
               mod_r[i] <= BUS_WDATA_IN;
               mod_r[i].rsv <= 1'b0;
            end
            // Count: a software byte write overrides the counting step.
            cnt_r[i] <= cnt_nxt[i];
            if (BUS_WR_IN && sel[i] && BUS_ADDR_IN == `MMT_OFS_CNTL) begin
               cnt_r[i][7:0] <= BUS_WDATA_IN;
            end
            if (BUS_WR_IN && sel[i] && BUS_ADDR_IN == `MMT_OFS_CNTH) begin
               cnt_r[i][15:8] <= BUS_WDATA_IN;
            end
            if (ext_ev[i] && mode[i] == mmt_pkg::MMT_CAPTURE) begin
               rcap_r[i] <= cnt_r[i];
            end else if (BUS_WR_IN && sel[i] && BUS_ADDR_IN == `MMT_OFS_RCAPL) begin
               rcap_r[i][7:0] <= BUS_WDATA_IN;
            end else if (BUS_WR_IN && sel[i] && BUS_ADDR_IN == `MMT_OFS_RCAPH) begin
               rcap_r[i][15:8] <= BUS_WDATA_IN;
            end
         end
      end
   end

   // Clock output divider: the pin toggles on every second overflow,
   // which gives the four-fold division of the overflow rate.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         half_r <= 3'h0;
         clk_r <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (mode[i] != mmt_pkg::MMT_CLKOUT) begin
               half_r[i] <= 1'b0;
               clk_r[i] <= 1'b0;
            end else if (ovf[i]) begin
               half_r[i] <= !half_r[i];
               if (half_r[i]) begin
                  clk_r[i] <= !clk_r[i];
               end
            end
         end
      end
   end

   // Registered outputs: pin drive, interrupts and baud ticks.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         TIMER_PIN_OUT <= 3'h0;
         TIMER_PIN_OE_OUT <= 3'h0;
         IRQ_OUT <= 3'h0;
         BAUD_TX_TICK_OUT <= 1'b0;
         BAUD_RX_TICK_OUT <= 1'b0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            TIMER_PIN_OUT[i] <= clk_r[i];
            TIMER_PIN_OE_OUT[i] <= (mode[i] == mmt_pkg::MMT_CLKOUT);
            IRQ_OUT[i] <= (ctl_r[i].tf || (ctl_r[i].exf && !down_count_enable_md[i])) &&
               ien_r[0] && ien_r[i+1];
         end
         // timer 2 overflow feeds the serial port
         BAUD_TX_TICK_OUT <= (mode[0] == mmt_pkg::MMT_BAUD) && ovf[0] && ctl_r[0].transmit_clock_select;
         BAUD_RX_TICK_OUT <= (mode[0] == mmt_pkg::MMT_BAUD) && ovf[0] && ctl_r[0].rclk;
      end
   end

   // Read data, valid in the cycle after the strobe only.
   // Reserved pointer codes read the shared set as zero.
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         BUS_RDATA_OUT <= 8'h00;
      end else begin
         BUS_RDATA_OUT <= 8'h00;
         if (BUS_RD_IN) begin
            for (int i = 0; i < 3; i++) begin
               if (sel[i]) begin
                  case (BUS_ADDR_IN)
                     `MMT_OFS_CTRL: BUS_RDATA_OUT <= ctl_r[i];
                     `MMT_OFS_MODE: BUS_RDATA_OUT <= mod_r[i];
                     `MMT_OFS_RCAPL: BUS_RDATA_OUT <= rcap_r[i][7:0];
                     `MMT_OFS_RCAPH: BUS_RDATA_OUT <= rcap_r[i][15:8];
                     `MMT_OFS_CNTL: BUS_RDATA_OUT <= cnt_r[i][7:0];
                     `MMT_OFS_CNTH: BUS_RDATA_OUT <= cnt_r[i][15:8];
                     default: BUS_RDATA_OUT <= 8'h00;
                  endcase
               end
            end
            if (BUS_ADDR_IN == `MMT_OFS_PTR) begin
               BUS_RDATA_OUT <= {5'h00, ptr_r};
            end else if (BUS_ADDR_IN == `MMT_OFS_IEN) begin
               BUS_RDATA_OUT <= {4'h0, ien_r};
            end
         end
      end
   end

   // Checks on timer 2; the other timers share the same logic.
   logic t2_wr;
   assign t2_wr = BUS_WR_IN && sel[0];

   property p_capture;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ext_ev[0] && mode[0] == mmt_pkg::MMT_CAPTURE |=> rcap_r[0] == $past(cnt_r[0]);
   endproperty
   a_capture: assert property (p_capture) else $error("capture lost count");

   property p_up_reload;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ovf[0] && up[0] && mode[0] == mmt_pkg::MMT_RELOAD && !t2_wr
      |=> ctl_r[0].tf && cnt_r[0] == $past(rcap_r[0]);
   endproperty
   a_up_reload: assert property (p_up_reload) else $error("reload missed");

   property p_down_top;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ovf[0] && !up[0] && !t2_wr |=> cnt_r[0] == `MMT_CNT_MAX;
   endproperty
   a_down_top: assert property (p_down_top) else $error("down match no top");

   property p_exf_toggle;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      down_count_enable_md[0] && ovf[0] |=> ctl_r[0].exf != $past(ctl_r[0].exf);
   endproperty
   a_exf_toggle: assert property (p_exf_toggle) else $error("bit 17 stuck");

   property p_baud_quiet;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      mode[0] == mmt_pkg::MMT_BAUD && ovf[0] && !ctl_r[0].tf && !t2_wr
      |=> !ctl_r[0].tf;
   endproperty
   a_baud_quiet: assert property (p_baud_quiet) else $error("baud set flag");

   property p_irq_gate;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      IRQ_OUT[0] |-> $past(ien_r[0]) && $past(ien_r[1]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

   property p_flag_hold;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      ctl_r[0].tf && !(t2_wr && BUS_ADDR_IN == `MMT_OFS_CTRL) |=> ctl_r[0].tf;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag self-cleared");

   property p_stopped;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      !ctl_r[0].run && !t2_wr && !ext_ev[0] |=> cnt_r[0] == $past(cnt_r[0]);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counts while stopped");

   property p_clk_oe;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (mode[0] == mmt_pkg::MMT_CLKOUT) [*2] |-> TIMER_PIN_OE_OUT[0];
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock pin not driven");

endmodule // mmt_timer

// ===== verif/mmt_pin_model.sv
// Far-side model of the trigger pins, timer pins and serial tick sinks.
module mmt_pin_model (
   input wire logic clk_in,
   input wire logic [2:0] pin_out_in,
   input wire logic [2:0] pin_oe_in,
   input wire logic tx_tick_in,
   input wire logic rx_tick_in,
   output logic [2:0] trig_out,
   output logic [2:0] pin_level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int tx_cnt; // Transmit ticks seen since the last clear.
   int rx_cnt; // Receive ticks seen since the last clear.
   int tog_cnt; // Timer 2 pin edges seen while the block drives it.
   logic last_pin_r; // Previous timer 2 pin level.
   logic [2:0] ext_lvl; // Level an outside source puts on each released timer pin.
   // Trigger pins and released timer pins idle high, as pulled-up lines would.
   initial begin
      trig_out = 3'h7;
      ext_lvl = 3'h7;
   end
   // The pin wire follows the block while it drives, else the outside source.
   assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_lvl);
   // Tally ticks and driven pin edges on every clock.
   always @(posedge clk_in) begin
      last_pin_r <= pin_level_out[0];
      if (tx_tick_in === 1'b1) begin
         tx_cnt++;
      end
      if (rx_tick_in === 1'b1) begin
         rx_cnt++;
      end
      if (pin_oe_in[0] === 1'b1 && pin_level_out[0] !== last_pin_r) begin
         tog_cnt++;
      end
   end
   // Sets one trigger level just after a clock edge.
   task set_trig(input int i, input logic v);
      @(posedge clk_in);
      trig_out[i] <= v;
   endtask
   // Pulse spans sync
   // A falling pulse held four clocks, then four clocks of recovery, so edges stay apart.
   // The same pulse can be put on a released timer pin instead, for counter mode.
   task pulse(input int i, input bit on_pin = 1'b0);
      @(posedge clk_in);
      if (on_pin) begin
         ext_lvl[i] <= 1'b0;
      end else begin
         trig_out[i] <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      if (on_pin) begin
         ext_lvl[i] <= 1'b1;
      end else begin
         trig_out[i] <= 1'b1;
      end
      repeat (4) @(posedge clk_in);
   endtask
   // Restarts all tallies.
   task clear_counts();
      tx_cnt = 0;
      rx_cnt = 0;
      tog_cnt = 0;
   endtask
endmodule // mmt_pin_model

// ===== verif/tb_mmt_timer.sv
// Self-checking bench of the shared timer 2/3/4 block.
`include "mmt_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_mmt_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk; // System clock, 100 MHz.
   logic rst_n; // Reset, active low.
   logic [7:0] bus_addr, bus_wdata, rdata, d;
   logic bus_wr, bus_rd, tx_tick, rx_tick;
   logic [2:0] trig, pin_lvl, pin_out, pin_oe, irq;
   int errors;
   int checks_done;
   // Clock generator.
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   mmt_timer uut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .BUS_ADDR_IN(bus_addr),
      .BUS_WDATA_IN(bus_wdata), .BUS_WR_IN(bus_wr), .BUS_RD_IN(bus_rd), .BUS_RDATA_OUT(rdata),
      .EXT_TRIG_IN(trig), .TIMER_PIN_IN(pin_lvl), .TIMER_PIN_OUT(pin_out),
      .TIMER_PIN_OE_OUT(pin_oe), .IRQ_OUT(irq), .BAUD_TX_TICK_OUT(tx_tick),
      .BAUD_RX_TICK_OUT(rx_tick));
   mmt_pin_model model (.clk_in(mclk), .pin_out_in(pin_out), .pin_oe_in(pin_oe),
      .tx_tick_in(tx_tick), .rx_tick_in(rx_tick), .trig_out(trig), .pin_level_out(pin_lvl));
   // Prints the counts and the verdict, then ends the run.
   task close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One-cycle write strobe; a spare cycle follows so strobes never merge.
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask
   // Sixteen-bit value as two bytes, low byte at the lower address.
   task wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, v[15:8]);
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Reads one register and compares it.
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      rd(a, d);
      `CHK(d, e)
   endtask
   // Writes, lets the interrupt settle, compares the timer 2 request.
   task wr_irq(input logic [7:0] a, input logic [7:0] v, input logic e);
      wr(a, v);
      repeat (3) @(posedge mclk);
      // The request is looked at once the edge that launched it has settled.
      #1;
      `CHK(irq[0], e)
   endtask
   // Polls until a masked bit is set; running out of tries ends the run.
   task poll(input logic [7:0] a, input logic [7:0] m);
      int n;
      for (n = 0; n < 200; n++) begin
         rd(a, d);
         if ((d & m) === m) break;
      end
      if (n == 200) begin
         errors++;
         $display("wrong value at %0t: wait ran out", $time);
         close_out();
      end
   endtask
   // Reset values of the whole map and an unmapped read.
   task t_reset();
      logic [7:0] a;
      for (int i = 0; i < 8; i++) begin
         a = `MMT_OFS_CTRL + i[7:0];
         rd(a, d);
         `CHK(d, (a == `MMT_OFS_PTR) ? {5'h00, `MMT_PTR_RST} : 8'h00)
      end
      rd_chk(8'h10, 8'h00);
   endtask
   // Up count with reload near the top; the flag must survive until cleared.
   task t_reload();
      wr16(`MMT_OFS_RCAPL, 16'hFFF0);
      wr16(`MMT_OFS_CNTL, 16'hFFFE);
      wr(`MMT_OFS_MODE, 8'h80);
      wr(`MMT_OFS_CTRL, 8'h04);
      poll(`MMT_OFS_CTRL, 8'h80);
      rd_chk(`MMT_OFS_CNTH, 8'hFF);
      wr(`MMT_OFS_CTRL, 8'h80);
      rd_chk(`MMT_OFS_CTRL, 8'h80);
      wr(`MMT_OFS_CTRL, 8'h00);
      rd_chk(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_MODE, 8'h00);
   endtask
   // Trigger edges with the counter stopped: capture, then reload.
   task t_trigger();
      wr16(`MMT_OFS_CNTL, 16'h1234);
      wr(`MMT_OFS_CTRL, 8'h09);
      model.pulse(0);
      rd_chk(`MMT_OFS_RCAPL, 8'h34);
      rd_chk(`MMT_OFS_RCAPH, 8'h12);
      rd_chk(`MMT_OFS_CTRL, 8'h49);
      rd_chk(`MMT_OFS_CNTL, 8'h34);
      wr16(`MMT_OFS_CNTL, 16'h0000);
      wr(`MMT_OFS_CTRL, 8'h48);
      model.pulse(0);
      rd_chk(`MMT_OFS_CNTL, 8'h34);
      rd_chk(`MMT_OFS_CNTH, 8'h12);
   endtask
   // Event flag is still set here; walk the enables and the flag writes.
   task t_irq();
      wr_irq(`MMT_OFS_IEN, 8'h02, 1'b0);
      wr_irq(`MMT_OFS_IEN, 8'h01, 1'b0);
      wr_irq(`MMT_OFS_IEN, 8'h03, 1'b1);
      wr_irq(`MMT_OFS_CTRL, 8'h00, 1'b0);
      wr_irq(`MMT_OFS_CTRL, 8'h80, 1'b1);
      wr_irq(`MMT_OFS_CTRL, 8'h00, 1'b0);
   endtask
   // Down count with the pin low: match on the reload value loads the top.
   task t_down();
      model.set_trig(0, 1'b0);
      wr16(`MMT_OFS_RCAPL, 16'h0005);
      wr16(`MMT_OFS_CNTL, 16'h0007);
      wr(`MMT_OFS_MODE, 8'h81);
      wr(`MMT_OFS_CTRL, 8'h04);
      poll(`MMT_OFS_CTRL, 8'h80);
      rd_chk(`MMT_OFS_CTRL, 8'hC4);
      rd_chk(`MMT_OFS_CNTH, 8'hFF);
      wr_irq(`MMT_OFS_CTRL, 8'h40, 1'b0);
      wr(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_MODE, 8'h00);
      model.set_trig(0, 1'b1);
   endtask
   // Baud generator on transmit only; count registers are left alone meanwhile.
   task t_baud();
      // no count writes running
      // Both words are set before the run bit, and nothing touches them until it clears.
      wr16(`MMT_OFS_RCAPL, 16'hFFF8);
      wr16(`MMT_OFS_CNTL, 16'hFFF8);
      model.clear_counts();
      wr(`MMT_OFS_CTRL, 8'h14);
      repeat (80) @(posedge mclk);
      wr(`MMT_OFS_CTRL, 8'h10);
      // Tallies and the request are read after the edge has settled.
      #1;
      `CHK(model.tx_cnt inside {[9:12]}, 1'b1)
      `CHK(model.rx_cnt == 0, 1'b1)
      `CHK(irq[0], 1'b0)
      rd_chk(`MMT_OFS_CTRL, 8'h10);
      wr(`MMT_OFS_CTRL, 8'h00);
   endtask
   // Clock output; a toggle every second overflow gives the documented rate.
   task t_clkout(input logic [7:0] mode, input int cyc, input int lo, input int hi);
      wr16(`MMT_OFS_RCAPL, 16'hFFFC);
      wr16(`MMT_OFS_CNTL, 16'hFFFC);
      wr(`MMT_OFS_MODE, mode);
      model.clear_counts();
      wr(`MMT_OFS_CTRL, 8'h04);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(pin_oe[0], 1'b1)
      repeat (cyc) @(posedge mclk);
      #1;
      `CHK(model.tog_cnt inside {[lo:hi]}, 1'b1)
      `CHK(irq[0], 1'b0)
      rd_chk(`MMT_OFS_CTRL, 8'h04);
      wr(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_MODE, 8'h00);
   endtask
   // Pointer picks a separate register set; reserved codes read as zero.
   task t_ptr();
      wr(`MMT_OFS_PTR, 8'h03);
      rd_chk(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_CTRL, 8'h3F);
      rd_chk(`MMT_OFS_CTRL, 8'h0F);
      wr(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_PTR, 8'h05);
      rd_chk(`MMT_OFS_RCAPL, 8'h00);
      wr(`MMT_OFS_PTR, 8'h02);
      rd_chk(`MMT_OFS_RCAPL, 8'hFC);
   endtask
   // Up count under the down-count enable, capture overflow, baud trigger edge,
   // counter mode and the timer 3 request line.
   task t_modes();
      // pin high counts up
      // A down count from here would need far longer than the poll allows.
      wr16(`MMT_OFS_RCAPL, 16'h8000);
      wr16(`MMT_OFS_CNTL, 16'hFFFE);
      wr(`MMT_OFS_MODE, 8'h81);
      wr(`MMT_OFS_CTRL, 8'h04);
      poll(`MMT_OFS_CTRL, 8'h80);
      rd_chk(`MMT_OFS_CNTH, 8'h80);
      rd_chk(`MMT_OFS_CTRL, 8'hC4);
      wr(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_MODE, 8'h80);
      wr16(`MMT_OFS_CNTL, 16'hFFFE);
      wr(`MMT_OFS_CTRL, 8'h05);
      poll(`MMT_OFS_CTRL, 8'h80);
      rd_chk(`MMT_OFS_CNTH, 8'h00);
      rd_chk(`MMT_OFS_CTRL, 8'h85);
      wr(`MMT_OFS_CTRL, 8'h00);
      wr16(`MMT_OFS_CNTL, 16'h1234);
      wr(`MMT_OFS_CTRL, 8'h18);
      model.pulse(0);
      rd_chk(`MMT_OFS_CTRL, 8'h58);
      rd_chk(`MMT_OFS_CNTL, 8'h34);
      wr(`MMT_OFS_CTRL, 8'h00);
      wr16(`MMT_OFS_CNTL, 16'h0000);
      wr(`MMT_OFS_CTRL, 8'h06);
      model.pulse(0, 1'b1);
      model.pulse(0, 1'b1);
      rd_chk(`MMT_OFS_CNTL, 8'h02);
      wr(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_MODE, 8'h00);
      // Timer 3 flag set by software, then its own enable beside the global one.
      wr(`MMT_OFS_PTR, 8'h03);
      wr(`MMT_OFS_CTRL, 8'h80);
      wr_irq(`MMT_OFS_IEN, 8'h05, 1'b0);
      `CHK(irq[1], 1'b1)
      wr(`MMT_OFS_CTRL, 8'h00);
      wr(`MMT_OFS_PTR, 8'h02);
   endtask
   // Main sequence: reset for six clocks, then every scenario in turn.
   initial begin
      errors = 0;
      checks_done = 0;
      rst_n = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_reload();
      t_trigger();
      t_irq();
      t_down();
      t_baud();
      t_clkout(8'h82, 160, 19, 22);
      t_clkout(8'h02, 480, 4, 6);
      t_ptr();
      t_modes();
      close_out();
   end
   // Guard against a hang anywhere in the sequence.
   initial begin
      #300000;
      errors++;
      $display("wrong value at %0t: run limit reached", $time);
      close_out();
   end
endmodule // tb_mmt_timer
